// ### rtl/rx_filter_regs.vh
// register offsets, field positions and reset values of the receive address / vlan filter block
`ifndef RX_FILTER_REGS_VH
`define RX_FILTER_REGS_VH

// register byte offsets
`define STATION_ADDR_LOW_BASE  16'h5400
`define STATION_ADDR_HIGH_BASE 16'h5404
`define STATION_ADDR_ALIAS_LO  16'h0040
`define STATION_ADDR_ALIAS_HI  16'h00bc
`define VLAN_FILTER_BASE       16'h5600
`define VLAN_FILTER_LAST       16'h57fc
`define VLAN_FILTER_ALIAS_LO   16'h0600
`define VLAN_FILTER_ALIAS_HI   16'h06fc
`define NVM_CTRL_OFFSET        16'h5800
`define MATCH_STATUS_OFFSET    16'h5804

// high word field positions
`define ADDR_HIGH_MSB          15
`define SELECT_LSB             16
`define SELECT_MSB             17
`define VALID_BIT              31

// select encodings
`define SELECT_DEST            2'h0
`define SELECT_SRC             2'h1

// reset values
`define ENTRY_ADDR_RESET       48'h000000000000
`define VLAN_WORD_RESET        32'h00000000

// axi responses
`define RESP_OKAY              2'h0
`define RESP_SLVERR            2'h2

`endif

// ### rtl/addr_match.v
// combinational exact-match compare of one station address entry
`timescale 1ns/1ps
`include "rx_filter_regs.vh"

module addr_match (
  input  wire [47:0] entryAddr,
  input  wire [1:0]  entrySelect,
  input  wire        entryValid,
  input  wire [47:0] frameDest,
  input  wire [47:0] frameSrc,
  output reg         hit
);

  // ----------------------------------------
  // compare chosen frame field
  // ----------------------------------------
  always @* begin
    hit = 1'b0;
    if (entryValid) begin
      case (entrySelect)
        `SELECT_DEST: hit = (entryAddr == frameDest);
        `SELECT_SRC:  hit = (entryAddr == frameSrc);
        default:      hit = 1'b0;
      endcase
    end
  end

endmodule

// ### rtl/rx_address_vlan_filter_tables.v
// receive address filter entries, vlan filter table and axi4-lite register slave
`timescale 1ns/1ps
`include "rx_filter_regs.vh"

module rx_address_vlan_filter_tables #(
  parameter ENTRIES    = 16,
  parameter VLAN_WORDS = 128
) (
  input  wire        clock,
  input  wire        rst_n,
  input  wire        powerOnRst_n,
  input  wire        nvmPresent,
  input  wire        nvmLoadDone,
  input  wire [47:0] storedIndividualAddress,
  input  wire        softResetPulse,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        frameValid,
  input  wire [47:0] frameDest,
  input  wire [47:0] frameSrc,
  input  wire        frameVlanValid,
  input  wire [11:0] frameVlanId,
  output reg         addrMatch,
  output reg         pauseDestMatch,
  output reg         vlanAccept
);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  reg [47:0] entryAddr_reg [0:ENTRIES-1];   // station addresses
  reg [1:0]  entrySel_reg  [0:ENTRIES-1];   // match select fields
  reg [ENTRIES-2:0] valid_reg;              // valid bits of entries 0..14
  reg        valid15_reg;                   // valid bit of entry 15, power-on only
  reg [31:0] vlanWord_reg  [0:VLAN_WORDS-1];// vlan filter words
  reg        nvmLoadPending_reg;            // entry zero load owed after reset

  // write channel latches
  reg [31:0] awAddr_reg;                    // captured write address
  reg        awHeld_reg;                    // write address captured
  reg [31:0] wData_reg;                     // captured write data
  reg [3:0]  wStrb_reg;                     // captured strobes
  reg        wHeld_reg;                     // write data captured

  integer i;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // returns {hit, isHigh, index[3:0]} for station entries
  function [5:0] decodeEntry;
    input [31:0] addr;
    reg   [15:0] off;
    begin
      off = addr[15:0];
      decodeEntry = 6'h00;
      if (addr[31:16] == 16'h0000 && addr[1:0] == 2'h0) begin
        if (off >= `STATION_ADDR_LOW_BASE && off <= `STATION_ADDR_HIGH_BASE + 16'h0078) begin
          off = off - `STATION_ADDR_LOW_BASE;
          decodeEntry = {1'b1, off[2], off[6:3]};
        end else if (off >= `STATION_ADDR_ALIAS_LO && off <= `STATION_ADDR_ALIAS_HI) begin
          off = off - `STATION_ADDR_ALIAS_LO;
          decodeEntry = {1'b1, off[2], off[6:3]};
        end
      end
    end
  endfunction

  // returns {hit, word index[6:0]} for vlan table
  function [7:0] decodeVlan;
    input [31:0] addr;
    reg   [15:0] off;
    begin
      off = addr[15:0];
      decodeVlan = 8'h00;
      if (addr[31:16] == 16'h0000 && addr[1:0] == 2'h0) begin
        if (off >= `VLAN_FILTER_BASE && off <= `VLAN_FILTER_LAST) begin
          off = off - `VLAN_FILTER_BASE;
          decodeVlan = {1'b1, off[8:2]};
        end else if (off >= `VLAN_FILTER_ALIAS_LO && off <= `VLAN_FILTER_ALIAS_HI) begin
          off = off - `VLAN_FILTER_ALIAS_LO;
          decodeVlan = {1'b1, 1'b0, off[7:2]};
        end
      end
    end
  endfunction

  // byte-lane merge of a write
  function [31:0] mergeBytes;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer b;
    begin
      mergeBytes = old;
      for (b = 0; b < 4; b = b + 1)
        if (strb[b])
          mergeBytes[8*b +: 8] = data[8*b +: 8];
    end
  endfunction

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  wire       doWrite  = awHeld_reg && wHeld_reg && !s_axi_bvalid;
  wire [5:0] wEntry   = decodeEntry(awAddr_reg);
  wire [7:0] wVlan    = decodeVlan(awAddr_reg);
  wire [3:0] wIdx     = wEntry[3:0];
  wire [ENTRIES-1:0] validAll = {valid15_reg, valid_reg};
  wire [31:0] highOld = {validAll[wIdx], 13'h0000, entrySel_reg[wIdx], entryAddr_reg[wIdx][47:32]};
  wire [31:0] highNew = mergeBytes(highOld, wData_reg, wStrb_reg);
  wire [31:0] lowNew  = mergeBytes(entryAddr_reg[wIdx][31:0], wData_reg, wStrb_reg);
  wire [31:0] vlanNew = mergeBytes(vlanWord_reg[wVlan[6:0]], wData_reg, wStrb_reg);
  wire        nvmStart = nvmPresent && (softResetPulse || nvmLoadDone || nvmLoadPending_reg);

  // ----------------------------------------
  // axi write channels
  // ----------------------------------------
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_reg    <= 1'b0;
      wHeld_reg     <= 1'b0;
      awAddr_reg    <= 32'h00000000;
      wData_reg     <= 32'h00000000;
      wStrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end else begin
      // accept address and data independently, one each
      s_axi_awready <= !awHeld_reg && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !wHeld_reg && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg    <= 1'b1;
        awAddr_reg    <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg    <= 1'b1;
        wData_reg    <= s_axi_wdata;
        wStrb_reg    <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      // both present: commit and respond
      if (doWrite) begin
        awHeld_reg   <= 1'b0;
        wHeld_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wEntry[5] || wVlan[7] || awAddr_reg[15:0] == `NVM_CTRL_OFFSET ||
                         awAddr_reg[15:0] == `MATCH_STATUS_OFFSET) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // entry storage, master reset domain
  // ----------------------------------------
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      valid_reg          <= {(ENTRIES-1){1'b0}};
      nvmLoadPending_reg <= 1'b1;
      for (i = 0; i < ENTRIES; i = i + 1) begin
        entryAddr_reg[i] <= `ENTRY_ADDR_RESET;
        entrySel_reg[i]  <= `SELECT_DEST;
      end
      for (i = 0; i < VLAN_WORDS; i = i + 1)
        vlanWord_reg[i] <= `VLAN_WORD_RESET;
    end else begin
      nvmLoadPending_reg <= 1'b0;
      if (doWrite && wEntry[5]) begin
        if (wEntry[4]) begin
          entryAddr_reg[wIdx][47:32] <= highNew[`ADDR_HIGH_MSB:0];
          entrySel_reg[wIdx]         <= highNew[`SELECT_MSB:`SELECT_LSB];
          if (wIdx != 4'hf)
            valid_reg[wIdx[3:0]]     <= highNew[`VALID_BIT];
        end else begin
          entryAddr_reg[wIdx][31:0]  <= lowNew;
        end
      end
      if (doWrite && wVlan[7])
        vlanWord_reg[wVlan[6:0]] <= vlanNew;
      // nvm image of entry zero wins over a same-cycle software write
      if (nvmStart) begin
        entryAddr_reg[0] <= storedIndividualAddress;
        entrySel_reg[0]  <= `SELECT_DEST;
        valid_reg[0]     <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // entry fifteen valid, power-on reset only
  // ----------------------------------------
  always @(posedge clock or negedge powerOnRst_n) begin
    if (!powerOnRst_n) begin
      valid15_reg <= 1'b0;
    end else if (doWrite && wEntry[5] && wEntry[4] && wIdx == 4'hf) begin
      valid15_reg <= highNew[`VALID_BIT];
    end
  end

  // ----------------------------------------
  // axi read channel
  // ----------------------------------------
  wire [5:0] rEntry = decodeEntry(s_axi_araddr);
  wire [7:0] rVlan  = decodeVlan(s_axi_araddr);
  wire [3:0] rIdx   = rEntry[3:0];

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `RESP_OKAY;
        if (rEntry[5] && rEntry[4])
          s_axi_rdata <= {validAll[rIdx], 13'h0000, entrySel_reg[rIdx],
                          entryAddr_reg[rIdx][47:32]};
        else if (rEntry[5])
          s_axi_rdata <= entryAddr_reg[rIdx][31:0];
        else if (rVlan[7])
          s_axi_rdata <= vlanWord_reg[rVlan[6:0]];
        else if (s_axi_araddr[15:0] == `NVM_CTRL_OFFSET && s_axi_araddr[31:16] == 16'h0000)
          s_axi_rdata <= {31'h00000000, nvmPresent};
        else if (s_axi_araddr[15:0] == `MATCH_STATUS_OFFSET && s_axi_araddr[31:16] == 16'h0000)
          s_axi_rdata <= {29'h00000000, vlanAccept, pauseDestMatch, addrMatch};
        else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // exact address match
  // ----------------------------------------
  wire [ENTRIES-1:0] entryHit;

  genvar g;
  generate
    for (g = 0; g < ENTRIES; g = g + 1) begin : gen_match
      addr_match u_match (
        .entryAddr   (entryAddr_reg[g]),
        .entrySelect (entrySel_reg[g]),
        .entryValid  (validAll[g]),
        .frameDest   (frameDest),
        .frameSrc    (frameSrc),
        .hit         (entryHit[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // registered filter results
  // ----------------------------------------
  wire [31:0] vlanSel = vlanWord_reg[frameVlanId[11:5]];

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      addrMatch      <= 1'b0;
      pauseDestMatch <= 1'b0;
      vlanAccept     <= 1'b0;
    end else begin
      addrMatch      <= frameValid && (|entryHit);
      pauseDestMatch <= frameValid && (entryAddr_reg[0] == frameDest);
      vlanAccept     <= frameVlanValid && vlanSel[frameVlanId[4:0]];
    end
  end

endmodule

// ### verif/rx_filter_checker_assertions.sv
// port assertions for the receive address and vlan filter block
`timescale 1ns/1ps
`include "rx_filter_regs.vh"
module rx_filter_checker (
  input wire        clock,
  input wire        rst_n,
  input wire        frameValid,
  input wire        addrMatch,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp
);
  // all checks on the one clock, quiet in master reset
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  AST_B_HOLD:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp lost");
  AST_R_HOLD:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata lost");
  AST_B_AFTER_WR:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("no write response");
  AST_R_AFTER_AR:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read response");
  AST_NO_AW_BUSY:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  AST_NO_AR_BUSY:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  AST_B_ONCE:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("double write response");
  AST_R_ONCE:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("double read response");
  AST_ERR_ZERO:
    assert property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 32'h0) else $error("error data");
  AST_MATCH_FRAME:
    assert property (addrMatch |-> $past(frameValid)) else $error("match without frame");
endmodule
bind rx_address_vlan_filter_tables rx_filter_checker rx_filter_checker_inst (.*);

// ### verif/rx_frame_source.sv
// incoming frame fields standing in for the line side
`timescale 1ns/1ps
module rx_frame_source (
  input  wire        clock,
  output reg         frameValid,
  output reg  [47:0] frameDest,
  output reg  [47:0] frameSrc,
  output reg         frameVlanValid,
  output reg  [11:0] frameVlanId
);
  // idle line at time zero
  initial begin
    frameValid = 1'b0;
    frameDest = 48'h0;
    frameSrc = 48'h0;
    frameVlanValid = 1'b0;
    frameVlanId = 12'h0;
  end
  // one tagged frame for one cycle, then fields scrambled
  task send(input [47:0] d, input [47:0] s, input [11:0] v);
    begin
      @(posedge clock);
      frameValid <= 1'b1;
      frameDest <= d;
      frameSrc <= s;
      frameVlanValid <= 1'b1;
      frameVlanId <= v;
      @(posedge clock);
      frameValid <= 1'b0;
      frameDest <= ~d;
      frameSrc <= ~s;
      frameVlanValid <= 1'b0;
      frameVlanId <= ~v;
    end
  endtask
endmodule

// ### verif/rx_address_vlan_filter_tables_test.sv
// self-checking bench of the receive address and vlan filter tables
`timescale 1ns/1ps
`include "rx_filter_regs.vh"
module rx_address_vlan_filter_tables_test;
  // ----------------------------------------
  // signals and model state
  // ----------------------------------------
  reg         clock, rst_n, powerOnRst_n, nvmPresent, nvmLoadDone, softResetPulse;
  reg  [47:0] storedIndividualAddress, a;
  reg  [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, rd, b, d;
  reg  [3:0]  s_axi_wstrb;
  reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        frameValid, frameVlanValid, addrMatch, pauseDestMatch, vlanAccept;
  wire [47:0] frameDest, frameSrc;
  wire [11:0] frameVlanId;
  integer     err_count, n_tests, cycles, seed, n, w;
  integer     wq[$];
  reg  [47:0] mAddr[0:15];
  reg  [1:0]  mSel[0:15];
  reg         mValid[0:15];
  reg  [31:0] mVlan[0:127];
  reg  [1:0]  rs;
  rx_address_vlan_filter_tables rx_address_vlan_filter_tables_inst (.*);
  rx_frame_source rx_frame_source_inst (.*);
  // ----------------------------------------
  // clock and hang guard
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial cycles = 0;
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 40000) begin
      err_count = err_count + 1;
      end_sim;
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task end_sim;
    begin
      if (err_count == 0 && n_tests > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // axi write, full word strobes only, response kept in rs
  task wr(input [31:0] ad, input [31:0] dt);
    reg aw, wd;
    begin
      @(posedge clock);
      s_axi_awaddr <= ad;
      s_axi_wdata <= dt;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      aw = 1'b0;
      wd = 1'b0;
      while (!(aw && wd)) begin
        @(posedge clock);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        aw = aw | s_axi_awready;
        wd = wd | s_axi_wready;
      end
      while (!s_axi_bvalid) @(posedge clock);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask
  // axi read, data in rd and response in rs
  task rdr(input [31:0] ad);
    begin
      @(posedge clock);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clock); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) @(posedge clock);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask
  task load0;
    begin
      mAddr[0] = storedIndividualAddress;
      mSel[0] = 2'h0;
      mValid[0] = 1'b1;
    end
  endtask
  task chkEntry(input integer k, input [31:0] base);
    begin
      rdr(base + 8 * k);
      chk("addr low", mAddr[k][31:0], rd);
      rdr(base + 8 * k + 4);
      chk("addr high", {mValid[k], 13'h0, mSel[k], mAddr[k][47:32]}, rd);
    end
  endtask
  // master reset and the model's view of it
  task doReset;
    begin
      rst_n <= 1'b0;
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      for (n = 0; n < 16; n = n + 1) begin
        mAddr[n] = 48'h0;
        mSel[n] = 2'h0;
        if (n < 15) mValid[n] = 1'b0;
      end
      for (n = 0; n < 128; n = n + 1) mVlan[n] = 32'h0;
      if (nvmPresent) load0;
    end
  endtask
  task frm(input [47:0] dd, input [47:0] ss, input [11:0] v);
    reg e;
    integer k;
    begin
      e = 1'b0;
      for (k = 0; k < 16; k = k + 1)
        e = e | (mValid[k] && ((mSel[k] == 2'h0 && mAddr[k] == dd) || (mSel[k] == 2'h1 && mAddr[k] == ss)));
      rx_frame_source_inst.send(dd, ss, v);
      @(negedge clock);
      chk("addrMatch", e, addrMatch);
      chk("pauseDestMatch", dd == mAddr[0], pauseDestMatch);
      chk("vlanAccept", mVlan[v[11:5]][v[4:0]], vlanAccept);
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h6422;
    err_count = 0;
    n_tests = 0;
    {rst_n, powerOnRst_n, nvmLoadDone, softResetPulse} = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hf;
    nvmPresent = 1'b1;
    storedIndividualAddress = {16'($random(seed)), 32'($random(seed))};
    mValid[15] = 1'b0;
    // one edge with power-on reset low so entry fifteen's valid bit starts known
    @(posedge clock);
    powerOnRst_n <= 1'b1;
    doReset;
    for (n = 0; n < 15; n = n + 1) chkEntry(n, 32'h5400);
    // program driver entries through one map, read through the other
    for (w = 0; w < 15; w = w + 1) begin
      a = {16'($random(seed)), 32'($random(seed))};
      mAddr[w] = a;
      mSel[w] = (w == 0) ? 2'h0 : 2'($random(seed));
      mValid[w] = 1'($random(seed));
      b = w[0] ? 32'h0040 : 32'h5400;
      wr(b + 8 * w, a[31:0]);
      chk("bresp", `RESP_OKAY, rs);
      wr(b + 8 * w + 4, {mValid[w], 13'($random(seed)), mSel[w], a[47:32]});
      chkEntry(w, w[0] ? 32'h5400 : 32'h0040);
    end
    // vlan words, alias for the lower half
    repeat (8) begin
      n = {$random(seed)} % 128;
      d = $random(seed);
      mVlan[n] = d;
      wq.push_back(n);
      wr((n < 64 ? 32'h0600 : 32'h5600) + 4 * n, d);
      rdr(32'h5600 + 4 * n);
      chk("vlan word", d, rd);
    end
    // frames against each entry, by destination and by source
    for (w = 0; w < 16; w = w + 1) begin
      n = wq[w % 8];
      frm(mAddr[w], {16'($random(seed)), 32'($random(seed))}, {n[6:0], 5'($random(seed))});
      frm({16'($random(seed)), 32'($random(seed))}, mAddr[w], {n[6:0], 5'($random(seed))});
    end
    // unmapped place
    wr(32'h5900, 32'hffffffff);
    chk("bresp", `RESP_SLVERR, rs);
    rdr(32'h5900);
    chk("rresp", `RESP_SLVERR, rs);
    chk("rdata", 32'h0, rd);
    // entry fifteen valid set once, only to prove its separate reset domain
    mValid[15] = 1'b1;
    wr(32'h547c, 32'h80000000);
    chk("bresp", `RESP_OKAY, rs);
    chkEntry(15, 32'h5400);
    // master reset without nvm: entry fifteen keeps its valid bit
    nvmPresent <= 1'b0;
    doReset;
    chkEntry(0, 32'h5400);
    rdr(32'h547c);
    chk("valid15", 1'b1, rd[31]);
    // software reset, then nvm read completion, reload entry zero
    nvmPresent <= 1'b1;
    softResetPulse <= 1'b1;
    @(posedge clock);
    softResetPulse <= 1'b0;
    load0;
    chkEntry(0, 32'h5400);
    wr(32'h5400, 32'h12345678);
    nvmLoadDone <= 1'b1;
    @(posedge clock);
    nvmLoadDone <= 1'b0;
    chkEntry(0, 32'h5400);
    frm(storedIndividualAddress, 48'h0, 12'h0);
    // power-on reset clears entry fifteen's valid bit
    @(posedge clock);
    powerOnRst_n <= 1'b0;
    @(posedge clock);
    powerOnRst_n <= 1'b1;
    rdr(32'h547c);
    chk("valid15", 1'b0, rd[31]);
    end_sim;
  end
endmodule
